//--- rtl/ostseq_pkg.sv
// Package for the output step trigger sequencer: constants, types and register map
package ostseq_pkg;

  // Avalon-MM register word offsets (byte address = 4 * index)
  localparam logic [3:0] OSTSEQ_REG_CTRL     = 4'h0;
  localparam logic [3:0] OSTSEQ_REG_CMD      = 4'h1;
  localparam logic [3:0] OSTSEQ_REG_VTRIG    = 4'h2;
  localparam logic [3:0] OSTSEQ_REG_ITRIG    = 4'h3;
  localparam logic [3:0] OSTSEQ_REG_VIMM     = 4'h4;
  localparam logic [3:0] OSTSEQ_REG_IIMM     = 4'h5;
  localparam logic [3:0] OSTSEQ_REG_OPCOND   = 4'h6;
  localparam logic [3:0] OSTSEQ_REG_IRQSTAT  = 4'h7;
  localparam logic [3:0] OSTSEQ_REG_IRQMASK  = 4'h8;

  // Control register fields
  localparam int OSTSEQ_CTRL_VMODE_BIT = 0;
  localparam int OSTSEQ_CTRL_IMODE_BIT = 1;

  // Command register fields (write-one pulses)
  localparam int OSTSEQ_CMD_INIT_BIT  = 0;
  localparam int OSTSEQ_CMD_TRIG_BIT  = 1;
  localparam int OSTSEQ_CMD_ABORT_BIT = 2;
  localparam int OSTSEQ_CMD_COMMON_BIT = 3;

  // Operation condition word
  localparam int OSTSEQ_OPC_WTG_BIT    = 4;
  localparam int OSTSEQ_OPC_ACTIVE_BIT = 6;

  // Interrupt status fields
  localparam int OSTSEQ_IRQ_WTG_BIT  = 0;
  localparam int OSTSEQ_IRQ_STEP_BIT = 1;
  localparam int OSTSEQ_IRQ_DROP_BIT = 2;
  localparam int OSTSEQ_IRQ_W        = 3;

  // Reset values
  localparam logic [15:0] OSTSEQ_LEVEL_RST = 16'h0000;

  // Settling time after initiate
  localparam int OSTSEQ_CLK_HZ     = 20_000_000;
  localparam int OSTSEQ_SETTLE_US  = 2000;
  localparam int OSTSEQ_SETTLE_CYC = (OSTSEQ_SETTLE_US * (OSTSEQ_CLK_HZ / 1_000_000));

  typedef enum logic { OSTSEQ_MODE_FIXED, OSTSEQ_MODE_STEP } ostseq_mode_e;

  typedef enum logic [1:0] { OSTSEQ_ST_IDLE, OSTSEQ_ST_SETTLE, OSTSEQ_ST_WAIT } ostseq_state_e;

  typedef struct packed {
    logic init;
    logic trig;
    logic abort;
  } ostseq_cmd_s;

  typedef struct packed {
    logic [15:0] volt;
    logic [15:0] curr;
  } ostseq_level_s;

  typedef struct packed {
    logic [3:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
  } ostseq_avm_req_s;

endpackage : ostseq_pkg

//--- rtl/ostseq_step_core.sv
// Transient trigger state machine with settling down-counter
`timescale 1ns/10ps
module ostseq_step_core
  import ostseq_pkg::*;
#(
  parameter int SETTLE_CYC = ostseq_pkg::OSTSEQ_SETTLE_CYC
) (
  // Clock and reset
  input  wire logic                 sys_clk_in,
  input  wire logic                 rst_b_in,
  // Commands
  input  wire ostseq_pkg::ostseq_cmd_s cmd_in,
  // Status
  output logic                      waiting_for_trigger_flag_out,
  output logic                      active_out,
  output logic                      initiated_out,
  output logic                      accept_out,
  output logic                      dropped_out
);
  import ostseq_pkg::*;

  localparam int CW = $clog2(SETTLE_CYC + 1);

  if (SETTLE_CYC < 1) begin : g_bad_settle
    $error("SETTLE_CYC must be at least 1");
  end

  typedef struct packed {
    ostseq_state_e st;
    logic [CW-1:0] cnt;
    logic          dropped;
  } ostseq_core_s;

  ostseq_core_s s_q;
  ostseq_core_s s_d;
  // Combinational accept so the setpoint copy lands on the same edge that returns to idle
  logic          accept_c;

  always_comb begin
    s_d         = s_q;
    s_d.dropped = 1'b0;
    accept_c    = 1'b0;
    case (s_q.st)
      OSTSEQ_ST_IDLE: begin
        if (cmd_in.init) begin
          s_d.st  = OSTSEQ_ST_SETTLE;
          s_d.cnt = CW'(SETTLE_CYC);
        end
        // Triggers in idle are ignored and do not raise dropped
      end
      OSTSEQ_ST_SETTLE: begin
        if (cmd_in.trig) begin
          s_d.dropped = 1'b1;
        end
        if (s_q.cnt <= CW'(1)) begin
          s_d.st = OSTSEQ_ST_WAIT;
        end else begin
          s_d.cnt = s_q.cnt - CW'(1);
        end
      end
      OSTSEQ_ST_WAIT: begin
        if (cmd_in.trig) begin
          accept_c = 1'b1;
          s_d.st   = OSTSEQ_ST_IDLE;
        end
      end
      default: begin
        s_d.st = OSTSEQ_ST_IDLE;
      end
    endcase
    if (cmd_in.abort) begin
      s_d.st   = OSTSEQ_ST_IDLE;
      accept_c = 1'b0;
    end
    if (!rst_b_in) begin
      s_d      = '0;
      accept_c = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    s_q <= s_d;
  end

  assign waiting_for_trigger_flag_out = (s_q.st == OSTSEQ_ST_WAIT);
  assign initiated_out                = (s_q.st != OSTSEQ_ST_IDLE);
  assign active_out                   = (s_q.st != OSTSEQ_ST_IDLE);
  assign accept_out                   = accept_c;
  assign dropped_out                  = s_q.dropped;

endmodule : ostseq_step_core

//--- rtl/ostseq_top.sv
// Output step trigger sequencer: Avalon-MM registers, trigger sources and setpoint update
//
// Our own choices: the Avalon-MM register port and the address map.
`timescale 1ns/10ps
module ostseq_top
  import ostseq_pkg::*;
#(
  parameter int SETTLE_CYC = ostseq_pkg::OSTSEQ_SETTLE_CYC,
  parameter int LEVEL_W    = 16
) (
  // Clock and reset
  input  wire logic               sys_clk_in,
  input  wire logic               rst_b_in,
  // Avalon-MM slave
  input  wire logic [3:0]         avs_address_in,
  input  wire logic               avs_read_in,
  input  wire logic               avs_write_in,
  input  wire logic [31:0]        avs_writedata_in,
  input  wire logic [3:0]         avs_byteenable_in,
  output logic [31:0]             avs_readdata_out,
  output logic                    avs_waitrequest_out,
  // Trigger sources
  input  wire logic               panel_trigger_in,
  input  wire logic               group_execute_trigger_in,
  // Setpoints to the output stage
  output logic [LEVEL_W-1:0]      voltage_setpoint_out,
  output logic [LEVEL_W-1:0]      current_setpoint_out,
  // Status
  output logic                    waiting_for_trigger_flag_out,
  output logic                    transient_active_out,
  output logic                    initiated_out,
  output logic                    irq_out
);
  import ostseq_pkg::*;

  if (LEVEL_W < 1 || LEVEL_W > 16) begin : g_bad_level_w
    $error("LEVEL_W must be 1..16");
  end

  typedef struct packed {
    logic [LEVEL_W-1:0]      vtrig;
    logic [LEVEL_W-1:0]      itrig;
    logic [LEVEL_W-1:0]      vimm;
    logic [LEVEL_W-1:0]      iimm;
    ostseq_mode_e            vmode;
    ostseq_mode_e            imode;
    logic [OSTSEQ_IRQ_W-1:0] irq_stat;
    logic [OSTSEQ_IRQ_W-1:0] irq_mask;
    logic [31:0]             rdata;
    logic                    ack;
    ostseq_cmd_s             cmd;
    logic                    wtg_prev;
  } ostseq_top_s;

  ostseq_top_s s_q;
  ostseq_top_s s_d;

  logic wtg;
  logic active;
  logic accept;
  logic dropped;

  ostseq_step_core #(
    .SETTLE_CYC (SETTLE_CYC)
  ) u_core (
    .sys_clk_in                   (sys_clk_in),
    .rst_b_in                     (rst_b_in),
    .cmd_in                       (s_q.cmd),
    .waiting_for_trigger_flag_out (wtg),
    .active_out                   (active),
    .initiated_out                (initiated_out),
    .accept_out                   (accept),
    .dropped_out                  (dropped)
  );

  function automatic logic [31:0] lvl32(input logic [LEVEL_W-1:0] v);
    lvl32 = 32'(v);
  endfunction : lvl32

  logic        req;
  logic        wr_done;
  logic [31:0] opcond;
  logic [OSTSEQ_IRQ_W-1:0] ev;

  always_comb begin
    opcond = 32'h0000_0000;
    opcond[OSTSEQ_OPC_WTG_BIT]    = wtg;
    opcond[OSTSEQ_OPC_ACTIVE_BIT] = active;
    ev = '0;
    ev[OSTSEQ_IRQ_WTG_BIT]  = wtg & ~s_q.wtg_prev;
    ev[OSTSEQ_IRQ_STEP_BIT] = accept;
    ev[OSTSEQ_IRQ_DROP_BIT] = dropped;
  end

  assign req = (avs_read_in | avs_write_in) & ~s_q.ack;
  // Writes land on the edge at which waitrequest is seen low
  assign wr_done = avs_write_in & s_q.ack;

  always_comb begin
    s_d          = s_q;
    s_d.ack      = req;
    s_d.cmd      = '0;
    s_d.wtg_prev = wtg;
    // Trigger sources merge regardless of any source selection
    s_d.cmd.trig = panel_trigger_in | group_execute_trigger_in;
    if (wr_done) begin
      case (avs_address_in)
        OSTSEQ_REG_CTRL: begin
          if (avs_byteenable_in[0]) begin
            s_d.vmode = ostseq_mode_e'(avs_writedata_in[OSTSEQ_CTRL_VMODE_BIT]);
            s_d.imode = ostseq_mode_e'(avs_writedata_in[OSTSEQ_CTRL_IMODE_BIT]);
          end
        end
        OSTSEQ_REG_CMD: begin
          if (avs_byteenable_in[0]) begin
            s_d.cmd.init  = avs_writedata_in[OSTSEQ_CMD_INIT_BIT];
            s_d.cmd.abort = avs_writedata_in[OSTSEQ_CMD_ABORT_BIT];
            s_d.cmd.trig  = s_d.cmd.trig | avs_writedata_in[OSTSEQ_CMD_TRIG_BIT]
                            | avs_writedata_in[OSTSEQ_CMD_COMMON_BIT];
          end
        end
        OSTSEQ_REG_VTRIG: begin
          if (&avs_byteenable_in[1:0]) s_d.vtrig = avs_writedata_in[LEVEL_W-1:0];
        end
        OSTSEQ_REG_ITRIG: begin
          if (&avs_byteenable_in[1:0]) s_d.itrig = avs_writedata_in[LEVEL_W-1:0];
        end
        OSTSEQ_REG_VIMM: begin
          if (&avs_byteenable_in[1:0]) s_d.vimm = avs_writedata_in[LEVEL_W-1:0];
        end
        OSTSEQ_REG_IIMM: begin
          if (&avs_byteenable_in[1:0]) s_d.iimm = avs_writedata_in[LEVEL_W-1:0];
        end
        OSTSEQ_REG_IRQMASK: begin
          if (avs_byteenable_in[0]) s_d.irq_mask = avs_writedata_in[OSTSEQ_IRQ_W-1:0];
        end
        default: begin
        end
      endcase
    end
    // Accepted trigger: only step-mode outputs take the triggered level
    if (accept) begin
      if (s_q.vmode == OSTSEQ_MODE_STEP) s_d.vimm = s_q.vtrig;
      if (s_q.imode == OSTSEQ_MODE_STEP) s_d.iimm = s_q.itrig;
    end
    s_d.rdata = 32'h0000_0000;
    if (req && avs_read_in) begin
      case (avs_address_in)
        OSTSEQ_REG_CTRL:    s_d.rdata = {30'h0000_0000, s_q.imode, s_q.vmode};
        OSTSEQ_REG_VTRIG:   s_d.rdata = lvl32(s_q.vtrig);
        OSTSEQ_REG_ITRIG:   s_d.rdata = lvl32(s_q.itrig);
        OSTSEQ_REG_VIMM:    s_d.rdata = lvl32(s_q.vimm);
        OSTSEQ_REG_IIMM:    s_d.rdata = lvl32(s_q.iimm);
        OSTSEQ_REG_OPCOND:  s_d.rdata = opcond;
        OSTSEQ_REG_IRQSTAT: s_d.rdata = 32'(s_q.irq_stat);
        OSTSEQ_REG_IRQMASK: s_d.rdata = 32'(s_q.irq_mask);
        default:            s_d.rdata = 32'h0000_0000;
      endcase
      if (avs_address_in == OSTSEQ_REG_IRQSTAT) s_d.irq_stat = '0;
    end
    // New events win over a clearing read
    s_d.irq_stat = s_d.irq_stat | ev;
    if (!rst_b_in) begin
      s_d          = '0;
      s_d.vmode    = OSTSEQ_MODE_FIXED;
      s_d.imode    = OSTSEQ_MODE_FIXED;
      s_d.vtrig    = OSTSEQ_LEVEL_RST[LEVEL_W-1:0];
      s_d.itrig    = OSTSEQ_LEVEL_RST[LEVEL_W-1:0];
      s_d.vimm     = OSTSEQ_LEVEL_RST[LEVEL_W-1:0];
      s_d.iimm     = OSTSEQ_LEVEL_RST[LEVEL_W-1:0];
    end
  end

  always_ff @(posedge sys_clk_in) begin
    s_q <= s_d;
  end

  assign avs_waitrequest_out          = (avs_read_in | avs_write_in) & ~s_q.ack;
  assign avs_readdata_out             = s_q.rdata;
  assign voltage_setpoint_out         = s_q.vimm;
  assign current_setpoint_out         = s_q.iimm;
  assign waiting_for_trigger_flag_out = wtg;
  assign transient_active_out         = active;
  assign irq_out                      = |(s_q.irq_stat & s_q.irq_mask);

endmodule : ostseq_top

//--- test/ostseq_sva.sv
// Port checker for the output step trigger sequencer
`timescale 1ns/10ps
module ostseq_sva #(
  parameter int SETTLE_CYC = 8,
  parameter int LEVEL_W    = 16
) (
  // Clock, reset and bus handshake
  input wire logic               sys_clk_in,
  input wire logic               rst_b_in,
  input wire logic               avs_read_in,
  input wire logic               avs_write_in,
  input wire logic               avs_waitrequest_out,
  // Triggers and status
  input wire logic               panel_trigger_in,
  input wire logic               group_execute_trigger_in,
  input wire logic [LEVEL_W-1:0] voltage_setpoint_out,
  input wire logic               waiting_for_trigger_flag_out,
  input wire logic               transient_active_out,
  input wire logic               initiated_out,
  input wire logic               irq_out
);
  localparam int SET_MAX = SETTLE_CYC + 4;
  default clocking cb @(posedge sys_clk_in); endclocking
  chk_wait_single: assert property (disable iff (!rst_b_in) (avs_read_in || avs_write_in) && avs_waitrequest_out
    |=> !avs_waitrequest_out) else $error("waitrequest held more than one cycle");
  chk_wait_first: assert property (disable iff (!rst_b_in) $rose(avs_read_in || avs_write_in)
    |-> avs_waitrequest_out) else $error("request answered without wait cycle");
  chk_wtg_active: assert property (disable iff (!rst_b_in)
    waiting_for_trigger_flag_out |-> transient_active_out) else $error("waiting while not active");
  chk_state_view: assert property (disable iff (!rst_b_in)
    initiated_out == transient_active_out) else $error("initiated and active disagree");
  chk_settle_hold: assert property (disable iff (!rst_b_in)
    $rose(transient_active_out) |-> !waiting_for_trigger_flag_out [*6]) else $error("ready too early");
  chk_settle_end: assert property (disable iff (!rst_b_in) $rose(transient_active_out)
    |-> ##[1:SET_MAX] (waiting_for_trigger_flag_out || !transient_active_out)) else $error("never ready");
  chk_step_idle: assert property (disable iff (!rst_b_in)
    $fell(waiting_for_trigger_flag_out) |-> ##[0:2] !transient_active_out) else $error("no return to idle");
  chk_idle_trig: assert property (disable iff (!rst_b_in) !transient_active_out
    && (panel_trigger_in || group_execute_trigger_in) |=> $stable(voltage_setpoint_out))
    else $error("idle trigger moved setpoint");
  chk_reset_clear: assert property (!rst_b_in |=> voltage_setpoint_out == '0 && !irq_out
    && !transient_active_out) else $error("reset state wrong");
  cov_ready: cover property (disable iff (!rst_b_in) $rose(waiting_for_trigger_flag_out));
  cov_step: cover property (disable iff (!rst_b_in) $fell(waiting_for_trigger_flag_out) ##1 !transient_active_out);
  cov_irq: cover property (disable iff (!rst_b_in) $rose(irq_out));
endmodule : ostseq_sva

//--- test/ostseq_ctl_model.sv
// Controller model driving the panel and group trigger lines
`timescale 1ns/10ps
module ostseq_ctl_model (
  // Clock
  input  wire logic sys_clk_in,
  // Trigger lines
  output logic      panel_trigger_out,
  output logic      group_execute_trigger_out
);
  initial begin
    panel_trigger_out         = 1'b0;
    group_execute_trigger_out = 1'b0;
  end
  // One-cycle pulse: sel 0 panel, 1 group
  task automatic fire(input logic sel);
    @(posedge sys_clk_in);
    if (sel) group_execute_trigger_out <= 1'b1;
    else panel_trigger_out <= 1'b1;
    @(posedge sys_clk_in);
    panel_trigger_out         <= 1'b0;
    group_execute_trigger_out <= 1'b0;
  endtask : fire
endmodule : ostseq_ctl_model

//--- test/ostseq_top_tb.sv
// Self-checking bench for the output step trigger sequencer
`timescale 1ns/10ps
module ostseq_top_tb;
  import ostseq_pkg::*;
  localparam int SETTLE_CYC = 8;
  logic        clk = 1'b0, rst_b = 1'b0, rd = 1'b0, wr = 1'b0;
  logic        pan, get, wreq, wtg, act, ini, irq;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wd = 32'h0, rdata;
  logic [15:0] vset, iset, vt, it, cv, ci;
  logic [31:0] exp_q[$];
  int          error_cnt = 0;
  int          n_tests = 0;
  ostseq_top #(.SETTLE_CYC(SETTLE_CYC)) dut (.sys_clk_in(clk), .rst_b_in(rst_b), .avs_address_in(addr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(4'hF),
    .avs_readdata_out(rdata), .avs_waitrequest_out(wreq), .panel_trigger_in(pan),
    .group_execute_trigger_in(get), .voltage_setpoint_out(vset), .current_setpoint_out(iset),
    .waiting_for_trigger_flag_out(wtg), .transient_active_out(act), .initiated_out(ini), .irq_out(irq));
  ostseq_ctl_model u_ctl (.sys_clk_in(clk), .panel_trigger_out(pan), .group_execute_trigger_out(get));
  initial begin
    forever #25 clk = ~clk;
  end
  task automatic give_verdict();
    $display("errors %0d checks %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : give_verdict
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wd   <= d;
    wr   <= w;
    rd   <= !w;
    do @(posedge clk); while (wreq !== 1'b0);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus
  task automatic rdc(input logic [3:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask : rdc
  // Read results are compared against the oldest note
  always @(posedge clk) begin
    if (rd && wreq === 1'b0) chk("readdata", exp_q.pop_front(), rdata);
  end
  task automatic wtg_wait();
    for (int k = 0; k < 40 && wtg !== 1'b1; k++) @(posedge clk);
  endtask : wtg_wait
  task automatic trig(input int s);
    if (s < 2) bus(1'b1, OSTSEQ_REG_CMD, (s == 1) ? 32'h8 : 32'h2);
    else u_ctl.fire(s[0]);
  endtask : trig
  task automatic newlv();
    vt = 16'($urandom);
    it = 16'($urandom);
    bus(1'b1, OSTSEQ_REG_VTRIG, {16'h0000, vt});
    bus(1'b1, OSTSEQ_REG_ITRIG, {16'h0000, it});
  endtask : newlv
  task automatic chklv();
    rdc(OSTSEQ_REG_VIMM, {16'h0000, cv});
    rdc(OSTSEQ_REG_IIMM, {16'h0000, ci});
    chk("vset", {16'h0000, cv}, {16'h0000, vset});
    chk("iset", {16'h0000, ci}, {16'h0000, iset});
  endtask : chklv
  initial begin
    void'($urandom(32'h57E3A4AF));
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    rdc(OSTSEQ_REG_OPCOND, 32'h0);
    rdc(OSTSEQ_REG_CTRL, 32'h0);
    bus(1'b1, 4'hF, 32'hFFFF);
    rdc(4'hF, 32'h0);
    cv = 16'($urandom);
    ci = 16'($urandom);
    bus(1'b1, OSTSEQ_REG_VIMM, {16'h0000, cv});
    bus(1'b1, OSTSEQ_REG_IIMM, {16'h0000, ci});
    newlv();
    trig(0);
    trig(2);
    chklv();
    bus(1'b1, OSTSEQ_REG_IRQMASK, 32'h2);
    bus(1'b1, OSTSEQ_REG_CTRL, 32'h3);
    for (int s = 0; s < 4; s++) begin
      newlv();
      bus(1'b1, OSTSEQ_REG_CMD, 32'h1);
      trig(0);
      rdc(OSTSEQ_REG_OPCOND, 32'h40);
      wtg_wait();
      rdc(OSTSEQ_REG_OPCOND, 32'h50);
      chk("status", 32'h7, {29'h0, wtg, act, ini});
      trig(s);
      cv = vt;
      ci = it;
      chklv();
      rdc(OSTSEQ_REG_OPCOND, 32'h0);
      chk("status", 32'h0, {29'h0, wtg, act, ini});
      if (s == 0) begin
        chk("irq", 32'h1, {31'h0, irq});
        rdc(OSTSEQ_REG_IRQSTAT, 32'h7);
        repeat (3) @(posedge clk);
        chk("irq", 32'h0, {31'h0, irq});
      end
    end
    newlv();
    bus(1'b1, OSTSEQ_REG_CMD, 32'h1);
    wtg_wait();
    bus(1'b1, OSTSEQ_REG_CMD, 32'h4);
    rdc(OSTSEQ_REG_OPCOND, 32'h0);
    trig(3);
    chklv();
    for (int m = 0; m < 3; m++) begin
      bus(1'b1, OSTSEQ_REG_CTRL, 32'(m));
      newlv();
      bus(1'b1, OSTSEQ_REG_CMD, 32'h1);
      wtg_wait();
      trig(1);
      if (m[0]) cv = vt;
      if (m[1]) ci = it;
      chklv();
    end
    give_verdict();
  end
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    give_verdict();
  end
endmodule : ostseq_top_tb
bind ostseq_top ostseq_sva #(.SETTLE_CYC(SETTLE_CYC), .LEVEL_W(LEVEL_W)) u_sva (.sys_clk_in(sys_clk_in),
  .rst_b_in(rst_b_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
  .avs_waitrequest_out(avs_waitrequest_out), .panel_trigger_in(panel_trigger_in),
  .group_execute_trigger_in(group_execute_trigger_in), .voltage_setpoint_out(voltage_setpoint_out),
  .waiting_for_trigger_flag_out(waiting_for_trigger_flag_out), .transient_active_out(transient_active_out),
  .initiated_out(initiated_out), .irq_out(irq_out));
